// ===== sip_serial_port.v
// The register offsets and the Avalon-MM register port were decided locally.
`timescale 1ns/10ps
`include "sip_consts.vh"
// Operation
// - port runs as clock master or slave, full or half duplex, up to 16 Mbit/s
// - master bit clock comes from peripheral clock via 3-bit divider, eight rates
// - frames are 8 or 16 bits; both ends shift the same count
// - hardware crc appended on transmit and checked on receive
// - every port instance offers an audio mode sharing logic and pins, master or slave
// - audio channel resolution 16 or 32 bits, direction input or output
// - audio clocking covers sample rates from 8 kHz to 192 kHz
// - audio master can drive a master clock at 256 times sample rate
// - transmit and receive requests go to a dma controller
module sip_serial_port #(
    parameter CW = 16
) (
    // clock, reset, clock enable
    input wire CLK,
    input wire RSTN,
    input wire CE,
    // avalon-mm slave
    input wire [4:0] AVS_ADDRESS,
    input wire AVS_READ,
    input wire AVS_WRITE,
    input wire [31:0] AVS_WRITEDATA,
    input wire [3:0] AVS_BYTEENABLE,
    output reg [31:0] AVS_READDATA,
    output wire AVS_WAITREQUEST,
    // interrupt and dma requests
    output wire IRQ,
    output wire TX_DMA_REQ,
    output wire RX_DMA_REQ,
    // serial clock pin
    input wire SCK_I,
    output reg SCK_O,
    output wire SCK_OE,
    // master-out line, also audio data
    input wire MOSI_I,
    output reg MOSI_O,
    output wire MOSI_OE,
    // master-in line
    input wire MISO_I,
    output wire MISO_O,
    output wire MISO_OE,
    // slave select and audio word select
    input wire NSS_I,
    output wire NSS_O,
    output wire NSS_OE,
    input wire WS_I,
    output reg WS_O,
    output wire WS_OE,
    // audio master clock
    output reg MCK_O
);
    localparam ST_IDLE = 2'b01;
    localparam ST_RUN = 2'b10;

    reg [31:0] ctrl;
    reg [3:0] imask;
    reg [3:0] sts;
    reg [CW-1:0] poly;
    reg [31:0] tx_buf;
    reg txe;
    reg [31:0] rx_data;
    reg rxne;
    reg [1:0] state;
    reg [31:0] tx_sh;
    reg [31:0] rx_sh;
    reg [11:0] cnt;
    reg [6:0] hcnt;
    reg [5:0] scnt;
    reg [7:0] mcnt;
    reg crc_pend;
    reg crc_phase;
    reg side;
    reg sck_p;
    reg ws_p;
    reg ack;
    reg [31:0] rdata;
    wire [4:0] pins_s;
    wire [CW-1:0] tcrc;
    wire [CW-1:0] tcrc_cur;
    wire [CW-1:0] rcrc;
    wire [CW-1:0] rcrc_cur;

    // control fields
    wire en = ctrl[`SIP_EN];
    wire mstr = ctrl[`SIP_MSTR];
    wire [2:0] br = ctrl[`SIP_BR_HI:`SIP_BR_LO];
    wire crc_en = ctrl[`SIP_CRCEN];
    wire bidi = ctrl[`SIP_BIDI];
    wire bidioe = ctrl[`SIP_BIDIOE];
    wire i2s = ctrl[`SIP_I2S];
    wire i2s32 = ctrl[`SIP_I2S32];
    wire i2stx = ctrl[`SIP_I2STX];
    wire [7:0] div = ctrl[`SIP_DIV_HI:`SIP_DIV_LO];
    wire sck_s = pins_s[0];
    wire mosi_s = pins_s[1];
    wire miso_s = pins_s[2];
    wire nss_s = pins_s[3];
    wire ws_s = pins_s[4];
    wire run = (state == ST_RUN);

    // audio mode takes over the same engine and pins
    wire master = i2s ? ctrl[`SIP_I2SM] : mstr;
    wire spi_m = master & ~i2s;
    // audio uses idle-low clock, sample on rising edge
    wire cpol_e = i2s ? 1'b0 : ctrl[`SIP_CPOL];
    wire cpha_e = i2s ? 1'b0 : ctrl[`SIP_CPHA];

    // bits per frame of the frame in flight
    wire [5:0] nbits = i2s ? (i2s32 ? 6'd32 : 6'd16) : ((crc_phase | ctrl[`SIP_F16]) ? 6'd16 : 6'd8);

    // half bit period: 2^br clocks, or a whole multiple of the master clock half period
    wire [11:0] mck_half = {4'h0, div} + 12'h001;
    wire [11:0] aud_half = mck_half << (i2s32 ? `SIP_MCK_SH32 : `SIP_MCK_SH16);
    wire [11:0] lim = i2s ? (aud_half - 12'h001) : ((12'h001 << br) - 12'h001);
    wire tick = master & run & (cnt == lim);

    // edges, from own clock as master or from the synchronised pin as slave
    wire lead_s = ~master & run & (sck_p == cpol_e) & (sck_s != cpol_e);
    wire trail_s = ~master & run & (sck_p != cpol_e) & (sck_s == cpol_e);
    wire lead = (tick & (SCK_O == cpol_e)) | lead_s;
    wire trail = (tick & (SCK_O != cpol_e)) | trail_s;
    wire sample_e = cpha_e ? trail : lead;
    wire shift_e = cpha_e ? lead : trail;

    // receive line: half duplex uses the single shared line
    wire rx_bit = i2s ? mosi_s : (master ? (bidi ? mosi_s : miso_s) : (bidi ? miso_s : mosi_s));
    wire [31:0] rx_nxt = {rx_sh[30:0], rx_bit};

    // frame end: master counts half periods, slave counts its own edges
    wire done_m = tick & (hcnt == ({nbits, 1'b0} - 7'd1));
    wire done_sv = cpha_e ? (sample_e & (scnt == nbits - 6'd1)) : (shift_e & (scnt == nbits));
    wire done = master ? done_m : done_sv;

    // next frame contents: crc word once requested, else buffer, else zeros
    wire crc_go = crc_pend & crc_en & ~crc_phase;
    wire [31:0] word = crc_go ? {{(32-CW){1'b0}}, tcrc_cur} : (txe ? 32'h00000000 : tx_buf);
    wire lw32 = i2s & i2s32;
    wire lw16 = i2s ? ~i2s32 : (crc_go | ctrl[`SIP_F16]);
    wire [31:0] al = lw32 ? word : (lw16 ? {word[15:0], 16'h0000} : {word[7:0], 24'h000000});

    // starting from idle, and continuing after a frame end
    wire go_idle = en & (master ? (i2s | ~txe | crc_go) : (i2s ? (ws_s != ws_p) : ~nss_s));
    wire go_more = i2s | (master ? (~txe | crc_go) : ~nss_s);
    wire start = (state == ST_IDLE) & go_idle;
    wire reload = run & done & go_more;
    wire load = start | reload;
    wire slave_stop = run & ~master & ~i2s & nss_s;
    wire crc_bad = run & done & crc_phase & (rcrc_cur != {CW{1'b0}});
    wire deliver = run & done & ~crc_phase;

    // bus access decode
    wire req = AVS_READ | AVS_WRITE;
    wire wr = AVS_WRITE & ack;
    wire [31:0] wm = {{8{AVS_BYTEENABLE[3]}}, {8{AVS_BYTEENABLE[2]}}, {8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};
    wire [31:0] wv = AVS_WRITEDATA & wm;
    wire wr_ctrl = wr & (AVS_ADDRESS == `SIP_CTRL);
    wire wr_data = wr & (AVS_ADDRESS == `SIP_DATA);
    wire wr_poly = wr & (AVS_ADDRESS == `SIP_POLY);
    wire rd_data = AVS_READ & ack & (AVS_ADDRESS == `SIP_DATA);
    wire [3:0] ev = {(deliver & rxne & ~rd_data), crc_bad, (load & ~txe & ~crc_go), deliver};

    // one wait state on every access
    assign AVS_WAITREQUEST = req & ~ack;
    assign IRQ = |(sts & imask);
    // dma asks for a word while the buffer is free or a word waits
    assign TX_DMA_REQ = ctrl[`SIP_TXDMA] & en & txe;
    assign RX_DMA_REQ = ctrl[`SIP_RXDMA] & rxne;

    // pin drive
    assign SCK_OE = en & master;
    assign MOSI_OE = en & (i2s ? i2stx : (master & (~bidi | bidioe)));
    assign MISO_O = MOSI_O;
    assign MISO_OE = en & ~i2s & ~master & ~nss_s & (~bidi | bidioe);
    assign NSS_O = ~(spi_m & run);
    assign NSS_OE = en & spi_m;
    assign WS_OE = en & i2s & master;

    // inputs from pins cross into this clock
    sip_sync #(
        .W(5)
    ) u_sync (
        .clk(CLK),
        .rst_n(RSTN),
        .ce(CE),
        .d({WS_I, NSS_I, MISO_I, MOSI_I, SCK_I}),
        .q(pins_s)
    );

    // transmit crc over sent bits, cleared after its own frame
    sip_crc #(
        .W(CW)
    ) u_tcrc (
        .clk(CLK),
        .rst_n(RSTN),
        .ce(CE),
        .clr(~crc_en | wr_poly | (run & done & crc_phase)),
        .en(crc_en & ~crc_phase & sample_e),
        .din(MOSI_O),
        .poly(poly),
        .crc(tcrc),
        .crc_cur(tcrc_cur)
    );

    // receive crc runs over data and crc word; zero left means good
    sip_crc #(
        .W(CW)
    ) u_rcrc (
        .clk(CLK),
        .rst_n(RSTN),
        .ce(CE),
        .clr(~crc_en | wr_poly | (run & done & crc_phase)),
        .en(crc_en & sample_e),
        .din(rx_bit),
        .poly(poly),
        .crc(rcrc),
        .crc_cur(rcrc_cur)
    );

    // register file and bus handshake
    always @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            ack <= 1'b0;
            rdata <= 32'h00000000;
            AVS_READDATA <= 32'h00000000;
            ctrl <= `SIP_CTRL_RST;
            imask <= `SIP_MASK_RST;
            poly <= `SIP_POLY_RST;
            sts <= 4'h0;
            tx_buf <= 32'h00000000;
            txe <= 1'b1;
            rxne <= 1'b0;
            rx_data <= 32'h00000000;
            crc_pend <= 1'b0;
        end else if (CE) begin
            ack <= req & ~ack;
            if (AVS_READ & ~ack) begin
                if (AVS_ADDRESS == `SIP_CTRL) begin
                    AVS_READDATA <= ctrl;
                end else if (AVS_ADDRESS == `SIP_STAT) begin
                    AVS_READDATA <= {20'h00000, side, run, rxne, txe, 4'h0, sts};
                end else if (AVS_ADDRESS == `SIP_MASK) begin
                    AVS_READDATA <= {28'h0000000, imask};
                end else if (AVS_ADDRESS == `SIP_DATA) begin
                    AVS_READDATA <= rx_data;
                end else if (AVS_ADDRESS == `SIP_POLY) begin
                    AVS_READDATA <= {{(32-CW){1'b0}}, poly};
                end else if (AVS_ADDRESS == `SIP_TCRC) begin
                    AVS_READDATA <= {{(32-CW){1'b0}}, tcrc};
                end else if (AVS_ADDRESS == `SIP_RCRC) begin
                    AVS_READDATA <= {{(32-CW){1'b0}}, rcrc};
                end else begin
                    AVS_READDATA <= 32'h00000000;
                end
            end
            // the request bit does not stay stored
            if (wr_ctrl) begin
                ctrl <= ((ctrl & ~wm) | wv) & ~(32'h00000001 << `SIP_CRCNX);
            end
            if (wr & (AVS_ADDRESS == `SIP_MASK)) begin
                imask <= (imask & ~wm[3:0]) | wv[3:0];
            end
            if (wr_poly) begin
                poly <= (poly & ~wm[CW-1:0]) | wv[CW-1:0];
            end
            // new events win over a one written to clear them
            if (wr & (AVS_ADDRESS == `SIP_STAT)) begin
                sts <= (sts & ~wv[3:0]) | ev;
            end else begin
                sts <= sts | ev;
            end
            if (wr_data) begin
                tx_buf <= (tx_buf & ~wm) | wv;
            end
            // a write in the same cycle as a load keeps the buffer full
            txe <= ~wr_data & (txe | (load & ~crc_go));
            rxne <= deliver | (rxne & ~rd_data);
            if (deliver) begin
                rx_data <= sample_e ? rx_nxt : rx_sh;
            end
            if (wr_ctrl & AVS_WRITEDATA[`SIP_CRCNX] & AVS_BYTEENABLE[1]) begin
                crc_pend <= 1'b1;
            end else if (load & crc_go) begin
                crc_pend <= 1'b0;
            end
        end
    end

    // serial engine
    always @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            state <= ST_IDLE;
            tx_sh <= 32'h00000000;
            rx_sh <= 32'h00000000;
            cnt <= 12'h000;
            hcnt <= 7'h00;
            scnt <= 6'h00;
            SCK_O <= 1'b0;
            MOSI_O <= 1'b0;
            WS_O <= 1'b0;
            side <= 1'b0;
            crc_phase <= 1'b0;
            sck_p <= 1'b0;
            ws_p <= 1'b0;
        end else if (CE) begin
            sck_p <= sck_s;
            ws_p <= ws_s;
            // divider runs only inside frames so every frame starts in phase
            cnt <= (run & master & ~tick & ~load) ? cnt + 12'h001 : 12'h000;
            if (~en | slave_stop | (run & done & ~go_more)) begin
                state <= ST_IDLE;
                SCK_O <= cpol_e;
                crc_phase <= 1'b0;
                if (~en) begin
                    WS_O <= 1'b0;
                end
            end else if (load) begin
                state <= ST_RUN;
                hcnt <= 7'h00;
                scnt <= 6'h00;
                rx_sh <= 32'h00000000;
                crc_phase <= crc_go;
                if (start) begin
                    SCK_O <= cpol_e;
                end else if (tick) begin
                    SCK_O <= ~SCK_O;
                end
                // channel side flips each word in audio mode
                WS_O <= start ? 1'b0 : ~WS_O;
                side <= master ? (start ? 1'b0 : ~WS_O) : ws_s;
                // first bit out now, or on the first leading edge
                if (!cpha_e) begin
                    MOSI_O <= al[31];
                    tx_sh <= {al[30:0], 1'b0};
                end else begin
                    tx_sh <= al;
                end
            end else if (run) begin
                if (tick) begin
                    SCK_O <= ~SCK_O;
                    hcnt <= hcnt + 7'd1;
                end
                if (sample_e) begin
                    rx_sh <= rx_nxt;
                    scnt <= scnt + 6'd1;
                end
                if (shift_e) begin
                    MOSI_O <= tx_sh[31];
                    tx_sh <= {tx_sh[30:0], 1'b0};
                end
            end else begin
                SCK_O <= cpol_e;
            end
        end
    end

    // master clock, 256 times the sample rate when enabled
    always @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            mcnt <= 8'h00;
            MCK_O <= 1'b0;
        end else if (CE) begin
            if (en & i2s & master & ctrl[`SIP_MCKEN]) begin
                mcnt <= (mcnt == div) ? 8'h00 : mcnt + 8'h01;
                if (mcnt == div) begin
                    MCK_O <= ~MCK_O;
                end
            end else begin
                mcnt <= 8'h00;
                MCK_O <= 1'b0;
            end
        end
    end
endmodule

// ===== sip_consts.vh
`ifndef SIP_CONSTS_VH
`define SIP_CONSTS_VH
// register byte offsets
`define SIP_CTRL 5'h00
`define SIP_STAT 5'h04
`define SIP_MASK 5'h08
`define SIP_DATA 5'h0c
`define SIP_POLY 5'h10
`define SIP_TCRC 5'h14
`define SIP_RCRC 5'h18
// control register fields
`define SIP_EN 0
`define SIP_MSTR 1
`define SIP_CPOL 2
`define SIP_CPHA 3
`define SIP_BR_LO 4
`define SIP_BR_HI 6
`define SIP_F16 7
`define SIP_CRCEN 8
`define SIP_CRCNX 9
`define SIP_BIDI 10
`define SIP_BIDIOE 11
`define SIP_I2S 12
`define SIP_I2SM 13
`define SIP_I2S32 14
`define SIP_I2STX 15
`define SIP_MCKEN 16
`define SIP_TXDMA 17
`define SIP_RXDMA 18
`define SIP_DIV_LO 24
`define SIP_DIV_HI 31
// status register: sticky events low, live state high
`define SIP_EV_RX 0
`define SIP_EV_TX 1
`define SIP_EV_CRC 2
`define SIP_EV_OVR 3
`define SIP_NEVT 4
`define SIP_ST_TXE 8
`define SIP_ST_RXNE 9
`define SIP_ST_BUSY 10
`define SIP_ST_SIDE 11
// reset values
`define SIP_CTRL_RST 32'h00000000
`define SIP_MASK_RST 4'h0
`define SIP_POLY_RST 16'h8005
// bit clock half period as a shift of master clock half periods (256 fs)
`define SIP_MCK_SH16 12'h003
`define SIP_MCK_SH32 12'h002
`endif

// ===== sip_sync.v
`timescale 1ns/10ps
module sip_sync #(
    parameter W = 5
) (
    // clock and reset
    input wire clk,
    input wire rst_n,
    input wire ce,
    // asynchronous levels in, synchronous levels out
    input wire [W-1:0] d,
    output reg [W-1:0] q
);
    reg [W-1:0] meta;

    // two stages; only the second stage is read outside
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= {W{1'b0}};
            q <= {W{1'b0}};
        end else if (ce) begin
            meta <= d;
            q <= meta;
        end
    end
endmodule

// ===== sip_crc.v
`timescale 1ns/10ps
module sip_crc #(
    parameter W = 16
) (
    // clock and reset
    input wire clk,
    input wire rst_n,
    input wire ce,
    // serial bit stream
    input wire clr,
    input wire en,
    input wire din,
    input wire [W-1:0] poly,
    // value so far, and value including this cycle's bit
    output reg [W-1:0] crc,
    output wire [W-1:0] crc_cur
);
    wire [W-1:0] upd;

    // msb-first, zero seed, so data plus its own crc leaves zero
    assign upd = {crc[W-2:0], 1'b0} ^ (((crc[W-1] ^ din) == 1'b1) ? poly : {W{1'b0}});
    assign crc_cur = en ? upd : crc;

    // clear wins over a bit arriving in the same cycle
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            crc <= {W{1'b0}};
        end else if (ce) begin
            crc <= clr ? {W{1'b0}} : crc_cur;
        end
    end
endmodule

// ===== sip_props.sv
`timescale 1ns/10ps
module sip_props (
    // clock and reset
    input wire CLK,
    input wire RSTN,
    // register bus
    input wire [4:0] AVS_ADDRESS,
    input wire AVS_READ,
    input wire AVS_WRITE,
    input wire [31:0] AVS_READDATA,
    input wire AVS_WAITREQUEST,
    // dma requests
    input wire TX_DMA_REQ,
    input wire RX_DMA_REQ,
    // pins
    input wire SCK_O,
    input wire SCK_OE,
    input wire MOSI_OE,
    input wire MISO_OE,
    input wire NSS_O,
    input wire NSS_OE,
    input wire WS_OE,
    input wire MCK_O
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RSTN);
    logic sck_d;
    logic [5:0] sck_cnt;
    wire rd_done = AVS_READ && !AVS_WAITREQUEST;
    wire wr_done = AVS_WRITE && !AVS_WAITREQUEST;
    // bit clock rises inside one select window; cleared while deselected
    always @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            sck_d <= 1'b0;
            sck_cnt <= 6'h00;
        end else begin
            sck_d <= SCK_O;
            if (NSS_O)
                sck_cnt <= 6'h00;
            else if (SCK_O && !sck_d)
                sck_cnt <= sck_cnt + 6'h01;
        end
    end
    // a request waits once, then completes
    sequence s_req;
        (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST;
    endsequence
    sequence s_ack;
        (AVS_READ || AVS_WRITE) && !AVS_WAITREQUEST;
    endsequence
    AST_ONE_WAIT: assert property (s_req |=> s_ack) else $error("bus wait longer than one cycle");
    AST_IDLE_NOWAIT: assert property (!(AVS_READ || AVS_WRITE) |-> !AVS_WAITREQUEST)
        else $error("wait request without a request");
    AST_UNMAPPED_ZERO: assert property (rd_done && AVS_ADDRESS == 5'h1c |-> AVS_READDATA == 32'h0)
        else $error("unmapped read not zero");
    AST_TXDMA_DROP: assert property (wr_done && AVS_ADDRESS == 5'h0c |=> !TX_DMA_REQ)
        else $error("tx dma request stays after data write");
    AST_RXDMA_DROP: assert property (rd_done && AVS_ADDRESS == 5'h0c |=> !RX_DMA_REQ)
        else $error("rx dma request stays after data read");
    AST_OE_EXCL: assert property (!(MOSI_OE && MISO_OE)) else $error("both data lines driven");
    AST_MASTER_PINS: assert property (NSS_OE |-> SCK_OE) else $error("select driven without clock");
    AST_FRAME_BITS: assert property ($rose(NSS_O) |-> sck_cnt != 6'h00 && sck_cnt[2:0] == 3'h0)
        else $error("frame not a whole number of bytes");
    AST_SCK_IDLE: assert property (NSS_OE && NSS_O && $past(NSS_O) |-> $stable(SCK_O))
        else $error("clock moves outside a frame");
    AST_MCK_AUDIO: assert property ($rose(MCK_O) |-> $past(WS_OE)) else $error("master clock outside audio master");
endmodule
bind sip_serial_port sip_props u_props (.CLK(CLK), .RSTN(RSTN), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
    .AVS_WRITE(AVS_WRITE), .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
    .TX_DMA_REQ(TX_DMA_REQ), .RX_DMA_REQ(RX_DMA_REQ), .SCK_O(SCK_O), .SCK_OE(SCK_OE), .MOSI_OE(MOSI_OE),
    .MISO_OE(MISO_OE), .NSS_O(NSS_O), .NSS_OE(NSS_OE), .WS_OE(WS_OE), .MCK_O(MCK_O));

// ===== sip_peer.sv
`timescale 1ns/10ps
module sip_peer (
    // serial pins seen from the far side
    input wire sck,
    input wire nss_n,
    input wire mosi,
    // word sent back in the next frame
    input wire [15:0] reply,
    output logic miso
);
    logic [15:0] sh = 16'h0000;
    logic [15:0] rx = 16'h0000;
    int bits = 0;
    int total = 0;
    initial miso = 1'b0;
    // selection loads the reply word, msb first
    always @(negedge nss_n) begin
        sh = reply;
        miso = reply[15];
        bits = 0;
    end
    // mode 0 only: sample on the rising edge
    always @(posedge sck) begin
        if (!nss_n) begin
            rx = {rx[14:0], mosi};
            bits++;
            total++;
        end
    end
    // shift on the falling edge; back to back frames continue the word
    always @(negedge sck) begin
        if (!nss_n) begin
            sh = {sh[14:0], 1'b0};
            miso = sh[15];
        end
    end
    // released line must not keep showing the last bit
    always @(posedge nss_n) miso = ~miso;
endmodule

// ===== sip_tb.sv
`timescale 1ns/10ps
`include "sip_consts.vh"
module testbench;
    logic CLK = 1'b0;
    logic RSTN = 1'b0;
    logic [4:0] AVS_ADDRESS = 5'h00;
    logic AVS_READ = 1'b0;
    logic AVS_WRITE = 1'b0;
    logic [31:0] AVS_WRITEDATA = 32'h00000000;
    wire [31:0] AVS_READDATA;
    wire AVS_WAITREQUEST, IRQ, TX_DMA_REQ, RX_DMA_REQ, SCK_O, SCK_OE, MOSI_O, MOSI_OE, MISO_O, MISO_OE;
    wire NSS_O, NSS_OE, WS_O, WS_OE, MCK_O, peer_miso;
    logic [15:0] reply = 16'h0000;
    logic [31:0] v;
    int errors = 0;
    int comparisons = 0;
    int cycles = 0;
    int n;
    logic ce = 1'b1;
    // pin levels resolved from the dut enables, the peer driving miso otherwise
    wire sck_w = SCK_OE ? SCK_O : 1'b0;
    wire mosi_w = MOSI_OE ? MOSI_O : 1'b0;
    wire miso_w = MISO_OE ? MISO_O : peer_miso;
    wire ws_w = WS_OE ? WS_O : 1'b0;
    sip_serial_port dut (.CLK(CLK), .RSTN(RSTN), .CE(ce), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
        .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(4'hf), .AVS_READDATA(AVS_READDATA),
        .AVS_WAITREQUEST(AVS_WAITREQUEST), .IRQ(IRQ), .TX_DMA_REQ(TX_DMA_REQ), .RX_DMA_REQ(RX_DMA_REQ),
        .SCK_I(sck_w), .SCK_O(SCK_O), .SCK_OE(SCK_OE), .MOSI_I(mosi_w), .MOSI_O(MOSI_O), .MOSI_OE(MOSI_OE),
        .MISO_I(miso_w), .MISO_O(MISO_O), .MISO_OE(MISO_OE), .NSS_I(1'b1), .NSS_O(NSS_O), .NSS_OE(NSS_OE),
        .WS_I(ws_w), .WS_O(WS_O), .WS_OE(WS_OE), .MCK_O(MCK_O));
    sip_peer peer (.sck(SCK_O), .nss_n(NSS_O), .mosi(MOSI_O), .reply(reply), .miso(peer_miso));
    // free running clock
    initial begin
        forever #5 CLK = ~CLK;
    end
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // hang guard, well above the few thousand cycles the tests need
    always @(posedge CLK) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            errors = errors + 1;
            give_verdict();
        end
    end
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // request held until waitrequest is sampled low
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        @(posedge CLK);
        AVS_ADDRESS <= a;
        AVS_WRITEDATA <= d;
        AVS_WRITE <= 1'b1;
        do @(posedge CLK); while (AVS_WAITREQUEST !== 1'b0);
        AVS_WRITE <= 1'b0;
        // the write lands at that edge; let flags settle before callers look
        @(negedge CLK);
    endtask
    task automatic rd(input logic [4:0] a, output logic [31:0] d);
        @(posedge CLK);
        AVS_ADDRESS <= a;
        AVS_READ <= 1'b1;
        do @(posedge CLK); while (AVS_WAITREQUEST !== 1'b0);
        d = AVS_READDATA;
        AVS_READ <= 1'b0;
    endtask
    // wait until the far side has seen n bits in all and the select is back up
    task automatic wait_done(input int total);
        int k;
        k = 0;
        while ((peer.total < total || NSS_O !== 1'b1) && k < 3000) begin
            @(posedge CLK);
            k++;
        end
        if (k == 3000)
            errors++;
        repeat (4) @(posedge CLK);
    endtask
    // cycles between two changes, skipping the first partial interval
    task automatic gap(input bit use_mck, output int g);
        logic last;
        last = use_mck ? MCK_O : WS_O;
        for (int p = 0; p < 2; p++) begin
            g = 0;
            do begin
                @(posedge CLK);
                g++;
            end while ((use_mck ? MCK_O : WS_O) === last && g < 3000);
            last = use_mck ? MCK_O : WS_O;
        end
    endtask
    // msb first, zero seed
    function automatic logic [15:0] crc_of(input logic [7:0] d);
        logic [15:0] c;
        c = 16'h0000;
        for (int i = 7; i >= 0; i--)
            c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? 16'h8005 : 16'h0000);
        return c;
    endfunction
    initial begin
        repeat (4) @(posedge CLK);
        RSTN <= 1'b1;
        rd(`SIP_CTRL, v); chk("ctrl reset", v, `SIP_CTRL_RST);
        rd(`SIP_MASK, v); chk("mask reset", v, 32'h0);
        rd(`SIP_POLY, v); chk("poly reset", v, {16'h0, `SIP_POLY_RST});
        rd(`SIP_STAT, v); chk("status reset", v, 32'h00000100);
        wr(5'h1c, 32'hffffffff);
        rd(5'h1c, v); chk("unmapped", v, 32'h0);
        $display("test reset done");
        wr(`SIP_MASK, 32'h1);
        wr(`SIP_CTRL, 32'h00000023);
        reply = 16'h3c00;
        wr(`SIP_DATA, 32'ha5);
        wait_done(8);
        chk("peer rx 8", {24'h0, peer.rx[7:0]}, 32'ha5);
        chk("peer bits 8", peer.bits, 8);
        rd(`SIP_STAT, v); chk("rx events", v & 32'h20f, 32'h203);
        chk("irq rx", {31'h0, IRQ}, 32'h1);
        rd(`SIP_DATA, v); chk("rx data 8", v, 32'h3c);
        wr(`SIP_STAT, 32'hf);
        chk("irq clear", {31'h0, IRQ}, 32'h0);
        $display("test frame8 done");
        wr(`SIP_CTRL, 32'h000000a3);
        reply = 16'hbeef;
        wr(`SIP_DATA, 32'h1234);
        wait_done(24);
        chk("peer rx 16", {16'h0, peer.rx}, 32'h1234);
        chk("peer bits 16", peer.bits, 16);
        rd(`SIP_DATA, v); chk("rx data 16", v, 32'hbeef);
        $display("test frame16 done");
        wr(`SIP_CTRL, 32'h00060023);
        chk("tx dma idle", {31'h0, TX_DMA_REQ}, 32'h1);
        reply = 16'h1122;
        wr(`SIP_DATA, 32'h01);
        wr(`SIP_DATA, 32'h02);
        wait_done(40);
        chk("rx dma", {31'h0, RX_DMA_REQ}, 32'h1);
        chk("peer rx second", {24'h0, peer.rx[7:0]}, 32'h02);
        rd(`SIP_STAT, v); chk("overrun", v & 32'h8, 32'h8);
        rd(`SIP_DATA, v); chk("rx overwritten", v, 32'h22);
        wr(`SIP_STAT, 32'hf);
        $display("test dma done");
        wr(`SIP_CTRL, 32'h00000123);
        wr(`SIP_POLY, 32'h8005);
        reply = 16'h5a00;
        wr(`SIP_DATA, 32'ha5);
        wait_done(48);
        rd(`SIP_DATA, v); chk("crc data", v, 32'h5a);
        reply = 16'h0000;
        wr(`SIP_CTRL, 32'h00000323);
        wait_done(64);
        chk("tx crc sent", {16'h0, peer.rx}, {16'h0, crc_of(8'ha5)});
        chk("crc bits", peer.bits, 16);
        rd(`SIP_STAT, v); chk("crc error", v & 32'h204, 32'h4);
        wr(`SIP_MASK, 32'h4);
        chk("irq crc", {31'h0, IRQ}, 32'h1);
        wr(`SIP_STAT, 32'h4);
        chk("irq crc clear", {31'h0, IRQ}, 32'h0);
        $display("test crc done");
        for (int r = 0; r < 2; r++) begin
            // stop first so a smaller divider never meets a counter above it
            wr(`SIP_CTRL, 32'h0);
            v = {8'(r + 1), 24'h01b001} | (r ? 32'h00004000 : 32'h0);
            wr(`SIP_CTRL, v);
            gap(1'b1, n); chk("mck half", n, r + 2);
            gap(1'b0, n); chk("ws half", n, 256 * (r + 2));
        end
        // low clock enable must hold the master clock still; 21 cycles is an odd toggle count
        @(posedge CLK);
        ce <= 1'b0;
        @(posedge CLK);
        v[0] = MCK_O;
        repeat (21) @(posedge CLK);
        chk("ce freeze", {31'h0, MCK_O}, {31'h0, v[0]});
        ce <= 1'b1;
        wr(`SIP_CTRL, 32'h0);
        repeat (8) @(posedge CLK);
        chk("mck off", {31'h0, MCK_O}, 32'h0);
        $display("test audio done");
        give_verdict();
    end
endmodule
